// *** pkg/ebc_pkg.sv ***
// constants and types of the external bus cycle and ready controller
// Summary of operation
// - With no waitstates a cycle lasts 4, 6 or 6, and 8 half-clock units for demux normal, demux extended or mux normal, and mux extended latch.
// - Each cycle grows by two units per command waitstate (15 minus wait field) and two more when the tristate field is 0.
// - The falling edge of the read and all write strobes is delayed one unit when the region's strobe delay bit is set.
// - The rising edge of all write strobes comes one unit early when the region's early write bit is set, except where that would remove the only low unit.
// - The command phase is stretched by programmed command waitstates or by READY sampled inactive.
// - After the command strobe one tristate waitstate is added when the region selects it.
// - Read data are caught on the edge that raises the read strobe; the address holds until the next cycle start.
// - In synchronous READY mode no extra stage is added, and the outside drives READY in step with the reference clock.
// - In asynchronous READY mode an extra stage is added and every READY cycle has at least one waitstate.
// - READY high at a sample point adds a waitstate, READY low ends the running cycle.
// - A multiplexed cycle is followed by a mux waitstate; demux without tristate wait has no gap.
// - One period of the reference clock output is exactly two half-clock units.
// - During writes the address stays put until the write strobe is high again.
package ebc_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int EBC_ADDR_W = 24;
	localparam int EBC_DATA_W = 16;
	localparam int EBC_CFG_W  = 11;
	localparam int EBC_REG_AW = 4;
	localparam int EBC_LEFT_W = 6;

	// ---------------------------------------------------------------
	// phase lengths in half-clock units
	// ---------------------------------------------------------------
	localparam logic [5:0] EBC_ALE_NORM_TCL  = 6'h01;
	localparam logic [5:0] EBC_ALE_EXT_TCL   = 6'h03;
	localparam logic [5:0] EBC_MUXA_TCL      = 6'h02;
	localparam logic [5:0] EBC_CMD_BASE_TCL  = 6'h02;
	localparam logic [5:0] EBC_END_TCL       = 6'h01;
	localparam logic [5:0] EBC_TRI_TCL       = 6'h02;
	localparam logic [5:0] EBC_MUXW_TCL      = 6'h02;
	localparam logic [5:0] EBC_SAMPLE_LEFT   = 6'h02;
	localparam logic [5:0] EBC_WAIT_RELOAD   = 6'h03;
	localparam logic [3:0] EBC_WAIT_FIELD_MAX = 4'hF;

	// ---------------------------------------------------------------
	// register map (plain port, word index)
	// ---------------------------------------------------------------
	localparam logic [3:0] EBC_OFS_CFG0   = 4'h0;
	localparam logic [3:0] EBC_OFS_STATUS = 4'h4;
	localparam logic [3:0] EBC_OFS_LENGTH = 4'h5;

	// region config fields
	localparam int EBC_F_WAIT_LO = 0;
	localparam int EBC_F_WAIT_HI = 3;
	localparam int EBC_F_TRI     = 4;
	localparam int EBC_F_ALE_EXT = 5;
	localparam int EBC_F_MUX     = 6;
	localparam int EBC_F_DELAY   = 7;
	localparam int EBC_F_EARLY   = 8;
	localparam int EBC_F_RDY_EN  = 9;
	localparam int EBC_F_RDY_ASY = 10;

	// no waits, no tristate wait, demux normal latch, no ready
	localparam logic [10:0] EBC_CFG_RESET = 11'h01F;

	typedef enum logic [2:0] {
		EBC_S_IDLE,
		EBC_S_ALE,
		EBC_S_MUXA,
		EBC_S_CMD,
		EBC_S_END,
		EBC_S_TRI,
		EBC_S_MUXW
	} ebc_state_t;

endpackage

// *** pkg/ebc_ready_if.sv ***
// ready path between the sequencer and the ready synchroniser
`timescale 1ns/100ps
interface ebc_ready_if;
	logic ready_n_pin;
	logic async_sel;
	logic ready_n_eff;

	modport seq  (output ready_n_pin, output async_sel, input ready_n_eff);
	modport sync (input ready_n_pin, input async_sel, output ready_n_eff);
endinterface

// *** verilog/ebc_ready_sync.sv ***
// ready input synchroniser with optional extra stage
`timescale 1ns/100ps
module ebc_ready_sync
	import ebc_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// ready path
	ebc_ready_if.sync       rdy
);

	logic meta_reg;
	logic sync_reg;
	logic extra_reg;

	// two flops for the pin; reset to not ready
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= rdy.ready_n_pin;
			sync_reg <= meta_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			extra_reg <= 1'b1;
		end else begin
			extra_reg <= sync_reg;
		end
	end

	// sync mode skips the extra stage
	assign rdy.ready_n_eff = rdy.async_sel ? extra_reg : sync_reg;

endmodule

// *** verilog/ebc_bus_ctrl.sv ***
// external bus cycle sequencer with waitstates and ready control
`timescale 1ns/100ps
module ebc_bus_ctrl
	import ebc_pkg::*;
#(
	parameter int REGIONS = 4
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// register port
	input  wire logic [EBC_REG_AW-1:0] reg_addr,
	input  wire logic [EBC_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [EBC_DATA_W-1:0] reg_rdata,
	// on-chip request
	input  wire logic                  req_valid,
	input  wire logic                  req_write,
	input  wire logic [EBC_ADDR_W-1:0] req_addr,
	input  wire logic [EBC_DATA_W-1:0] req_wdata,
	input  wire logic [1:0]            req_be,
	input  wire logic [1:0]            req_region,
	output logic                       req_ready,
	output logic                       rsp_valid,
	output logic      [EBC_DATA_W-1:0] rsp_rdata,
	// external bus pins
	output logic                       bus_reference_clock_out,
	output logic      [EBC_ADDR_W-1:0] addr_out,
	input  wire logic [EBC_DATA_W-1:0] ad_i,
	output logic      [EBC_DATA_W-1:0] ad_o,
	output logic                       ad_oe,
	output logic                       ale,
	output logic                       read_n,
	output logic                       write_n,
	output logic                       write_low_byte_n,
	output logic                       write_high_byte_n,
	output logic                       write_select_n,
	output logic                       read_select_n,
	output logic                       upper_byte_enable_n,
	input  wire logic                  ready_n
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [EBC_CFG_W-1:0]  cfg_reg [REGIONS];
	logic [EBC_CFG_W-1:0]  cur_cfg_reg;
	logic [EBC_CFG_W-1:0]  sel_cfg;
	ebc_state_t            state_reg;
	ebc_state_t            state_next;
	logic [EBC_LEFT_W-1:0] left_reg;
	logic [EBC_LEFT_W-1:0] left_next;
	logic                  force_wait_reg;
	logic                  force_wait_next;
	logic                  write_reg;
	logic [EBC_ADDR_W-1:0] addr_reg;
	logic [EBC_DATA_W-1:0] wdata_reg;
	logic [1:0]            be_reg;
	logic [7:0]            len_cnt_reg;
	logic [7:0]            len_last_reg;
	logic                  start;
	logic                  rd_strobe_next;
	logic                  wr_strobe_next;
	logic                  is_mux;

	ebc_ready_if rdy_if ();

	ebc_ready_sync u_ready_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.rdy     (rdy_if.sync)
	);

	assign rdy_if.ready_n_pin = ready_n;
	assign rdy_if.async_sel   = cur_cfg_reg[EBC_F_RDY_ASY];
	assign start              = req_valid && req_ready;
	assign sel_cfg            = cfg_reg[req_region];
	assign is_mux             = cur_cfg_reg[EBC_F_MUX];

	// ---------------------------------------------------------------
	// phase length helpers
	// ---------------------------------------------------------------
	// two units per command waitstate
	function automatic logic [EBC_LEFT_W-1:0] cmd_len(input logic [EBC_CFG_W-1:0] c);
		logic [3:0] waits;
		waits = EBC_WAIT_FIELD_MAX - c[EBC_F_WAIT_HI:EBC_F_WAIT_LO];
		return EBC_CMD_BASE_TCL + {1'b0, waits, 1'b0};
	endfunction

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	// config writes; the sequencer copies its region at cycle start
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < REGIONS; i++) begin
				cfg_reg[i] <= EBC_CFG_RESET;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < REGIONS; i++) begin
				if (reg_addr == EBC_OFS_CFG0 + EBC_REG_AW'(i)) begin
					cfg_reg[i] <= reg_wdata[EBC_CFG_W-1:0];
				end
			end
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				for (int i = 0; i < REGIONS; i++) begin
					if (reg_addr == EBC_OFS_CFG0 + EBC_REG_AW'(i)) begin
						reg_rdata <= {{(EBC_DATA_W-EBC_CFG_W){1'b0}}, cfg_reg[i]};
					end
				end
				if (reg_addr == EBC_OFS_STATUS) begin
					reg_rdata <= {11'h000, rdy_if.ready_n_eff, state_reg != EBC_S_IDLE, 3'(state_reg)};
				end
				if (reg_addr == EBC_OFS_LENGTH) begin
					reg_rdata <= {8'h00, len_last_reg};
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// cycle sequencer
	// ---------------------------------------------------------------
	// address, latch, command, data order
	always_comb begin
		state_next      = state_reg;
		left_next       = left_reg - 6'h01;
		force_wait_next = force_wait_reg;
		case (state_reg)
			EBC_S_IDLE: begin
				left_next = left_reg;
				if (start) begin
					state_next      = EBC_S_ALE;
					left_next       = sel_cfg[EBC_F_ALE_EXT] ? EBC_ALE_EXT_TCL : EBC_ALE_NORM_TCL;
					force_wait_next = sel_cfg[EBC_F_RDY_EN] && sel_cfg[EBC_F_RDY_ASY];
				end
			end
			EBC_S_ALE: begin
				if (left_reg == 6'h01) begin
					// mux adds an address hold phase
					state_next = is_mux ? EBC_S_MUXA : EBC_S_CMD;
					left_next  = is_mux ? EBC_MUXA_TCL : cmd_len(cur_cfg_reg);
				end
			end
			EBC_S_MUXA: begin
				if (left_reg == 6'h01) begin
					state_next = EBC_S_CMD;
					left_next  = cmd_len(cur_cfg_reg);
				end
			end
			EBC_S_CMD: begin
				// ready high at the sample point adds a wait
				if (left_reg == EBC_SAMPLE_LEFT && cur_cfg_reg[EBC_F_RDY_EN]) begin
					force_wait_next = 1'b0;
					// stretch command phase by two units
					if (rdy_if.ready_n_eff || force_wait_reg) begin
						left_next = EBC_WAIT_RELOAD;
					end
				end else if (left_reg == 6'h01) begin
					state_next = EBC_S_END;
					left_next  = EBC_END_TCL;
				end
			end
			EBC_S_END: begin
				if (left_reg == 6'h01) begin
					// tristate wait when field is zero
					if (!cur_cfg_reg[EBC_F_TRI]) begin
						state_next = EBC_S_TRI;
						left_next  = EBC_TRI_TCL;
					end else if (is_mux) begin
						state_next = EBC_S_MUXW;
						left_next  = EBC_MUXW_TCL;
					end else begin
						state_next = EBC_S_IDLE;
					end
				end
			end
			EBC_S_TRI: begin
				if (left_reg == 6'h01) begin
					state_next = is_mux ? EBC_S_MUXW : EBC_S_IDLE;
					left_next  = EBC_MUXW_TCL;
				end
			end
			EBC_S_MUXW: begin
				// mux gap before the next cycle
				if (left_reg == 6'h01) begin
					state_next = EBC_S_IDLE;
				end
			end
			default: begin
				state_next = EBC_S_IDLE;
				left_next  = '0;
			end
		endcase
	end

	// state and phase counter
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg      <= EBC_S_IDLE;
			left_reg       <= '0;
			force_wait_reg <= 1'b0;
		end else begin
			state_reg      <= state_next;
			left_reg       <= left_next;
			force_wait_reg <= force_wait_next;
		end
	end

	// request capture; held for the whole cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_cfg_reg <= EBC_CFG_RESET;
			write_reg   <= 1'b0;
			addr_reg    <= '0;
			wdata_reg   <= '0;
			be_reg      <= 2'h0;
		end else if (start) begin
			cur_cfg_reg <= sel_cfg;
			write_reg   <= req_write;
			addr_reg    <= req_addr;
			wdata_reg   <= req_wdata;
			be_reg      <= req_be;
		end
	end

	// cycle length in units, latch to idle gap excluded
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			len_cnt_reg  <= 8'h00;
			len_last_reg <= 8'h00;
		end else if (state_next == EBC_S_ALE && state_reg == EBC_S_IDLE) begin
			len_cnt_reg <= 8'h01;
		end else if (state_next inside {EBC_S_ALE, EBC_S_MUXA, EBC_S_CMD, EBC_S_END, EBC_S_TRI}) begin
			len_cnt_reg <= len_cnt_reg + 8'h01;
		end else if (state_reg inside {EBC_S_END, EBC_S_TRI}) begin
			len_last_reg <= len_cnt_reg;
		end
	end

	// ---------------------------------------------------------------
	// strobes
	// ---------------------------------------------------------------
	always_comb begin
		rd_strobe_next = 1'b0;
		wr_strobe_next = 1'b0;
		if (state_next == EBC_S_CMD) begin
			// delayed falling edge skips the first unit
			if (!(cur_cfg_reg[EBC_F_DELAY] && state_reg != EBC_S_CMD)) begin
				rd_strobe_next = !write_reg;
				wr_strobe_next = write_reg;
			end
			// early write ends one unit sooner, but never cuts the only low unit
			// (delay plus early with no waits would otherwise leave a write without a strobe)
			if (cur_cfg_reg[EBC_F_EARLY] && left_next == 6'h01 && !write_n) begin
				wr_strobe_next = 1'b0;
			end
		end
	end

	// strobe pins, registered from the next state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			read_n            <= 1'b1;
			read_select_n     <= 1'b1;
			write_n           <= 1'b1;
			write_select_n    <= 1'b1;
			write_low_byte_n  <= 1'b1;
			write_high_byte_n <= 1'b1;
			ale               <= 1'b0;
		end else begin
			read_n            <= !rd_strobe_next;
			read_select_n     <= !rd_strobe_next;
			write_n           <= !wr_strobe_next;
			write_select_n    <= !wr_strobe_next;
			write_low_byte_n  <= !(wr_strobe_next && be_reg[0]);
			write_high_byte_n <= !(wr_strobe_next && be_reg[1]);
			ale               <= state_next == EBC_S_ALE;
		end
	end

	// ---------------------------------------------------------------
	// address and data pins
	// ---------------------------------------------------------------
	// address changes only at a new cycle start
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_out            <= '0;
			upper_byte_enable_n <= 1'b1;
		end else if (start) begin
			addr_out            <= req_addr;
			upper_byte_enable_n <= !req_be[1];
		end
	end

	// mux drives address then data on the shared port
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ad_o  <= '0;
			ad_oe <= 1'b0;
		end else begin
			ad_o  <= '0;
			ad_oe <= 1'b0;
			if (state_next inside {EBC_S_ALE, EBC_S_MUXA} && (start ? sel_cfg[EBC_F_MUX] : is_mux)) begin
				ad_o  <= start ? req_addr[EBC_DATA_W-1:0] : addr_reg[EBC_DATA_W-1:0];
				ad_oe <= 1'b1;
			end else if (state_next inside {EBC_S_CMD, EBC_S_END} && write_reg) begin
				ad_o  <= wdata_reg;
				ad_oe <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// request handshake and read data
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			req_ready <= state_next == EBC_S_IDLE && !start;
			rsp_valid <= state_reg == EBC_S_CMD && state_next == EBC_S_END;
			// catch data on the strobe's rising edge
			if (state_reg == EBC_S_CMD && state_next == EBC_S_END && !write_reg) begin
				rsp_rdata <= ad_i;
			end
		end
	end

	// reference clock period is two units
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_reference_clock_out <= 1'b0;
		end else begin
			bus_reference_clock_out <= !bus_reference_clock_out;
		end
	end

endmodule

// *** test/ebc_mem_model.sv ***
// external memory with a ready answer, standing on the bus pins
`timescale 1ns/100ps
module ebc_mem_model
	import ebc_pkg::*;
(
	// clock
	input  wire logic                  ref_clk,
	// bus pins
	input  wire logic [EBC_ADDR_W-1:0] addr_out,
	input  wire logic [EBC_DATA_W-1:0] ad_o,
	input  wire logic                  read_n,
	input  wire logic                  write_low_byte_n,
	input  wire logic                  write_high_byte_n,
	output logic      [EBC_DATA_W-1:0] ad_i,
	// ready answer
	input  wire logic [3:0]            rdy_dly,
	output logic                       ready_n
);
	logic [EBC_DATA_W-1:0] mem [16];
	logic [EBC_DATA_W-1:0] last_q;
	logic [3:0]            cnt;
	logic                  cmd;

	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		last_q = 16'h0000;
	end
	// byte lanes; plain always since the array is also cleared at time zero
	always @(posedge ref_clk) begin
		if (!write_low_byte_n) mem[addr_out[3:0]][7:0] <= ad_o[7:0];
		if (!write_high_byte_n) mem[addr_out[3:0]][15:8] <= ad_o[15:8];
		if (!read_n) last_q <= mem[addr_out[3:0]];
	end
	// released bus shows the inverse of the last word, so a late capture reads wrong
	assign ad_i = read_n ? ~last_q : mem[addr_out[3:0]];
	// ready low after rdy_dly cycles of strobe, dropped with the strobe rise
	assign cmd = !read_n || !write_low_byte_n || !write_high_byte_n;
	always_ff @(posedge ref_clk) begin
		cnt <= cmd ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
	end
	assign ready_n = !(cmd && cnt >= rdy_dly);
endmodule

// *** test/ebc_bus_ctrl_chk.sv ***
// concurrent checks on the bus sequencer ports
`timescale 1ns/100ps
module ebc_bus_ctrl_chk
	import ebc_pkg::*;
(
	// clock and reset
	input wire logic                  ref_clk,
	input wire logic                  rst_n,
	// request side
	input wire logic                  req_valid,
	input wire logic                  req_ready,
	input wire logic                  rsp_valid,
	input wire logic [1:0]            req_be,
	// bus pins
	input wire logic                  bus_reference_clock_out,
	input wire logic [EBC_ADDR_W-1:0] addr_out,
	input wire logic                  ad_oe,
	input wire logic                  ale,
	input wire logic                  read_n,
	input wire logic                  write_n,
	input wire logic                  write_low_byte_n,
	input wire logic                  write_high_byte_n,
	input wire logic                  write_select_n,
	input wire logic                  read_select_n,
	input wire logic                  upper_byte_enable_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_bus_reference_clock_out_toggle: assert property ($past(rst_n) |-> bus_reference_clock_out != $past(bus_reference_clock_out))
		else $error("clock output missed a toggle");
	a_ale_no_cmd: assert property (ale |-> read_n && write_n)
		else $error("latch strobe overlaps a command");
	a_read_no_drive: assert property (!read_n |-> !ad_oe)
		else $error("data bus driven during read");
	a_min_cycle: assert property (req_valid && req_ready |=> !rsp_valid [*3])
		else $error("cycle ended too early");
	a_rsp_bound: assert property (req_valid && req_ready |-> ##[4:200] rsp_valid)
		else $error("cycle never ended");
	// capture with the read strobe rise
	a_read_capture: assert property ($rose(read_n) |-> rsp_valid)
		else $error("read strobe rose without capture");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && !req_valid || !rsp_valid)
		else $error("response held too long");
	a_addr_hold_wr: assert property (!write_n || $rose(write_n) |-> $stable(addr_out))
		else $error("address moved during write");
	// write strobe variants share their edges
	a_wstrobe_group: assert property (write_select_n == write_n && (write_low_byte_n || !write_n)
		&& (write_high_byte_n || !write_n))
		else $error("write strobes disagree");
	// read select shares the read strobe edges
	a_rdsel_follow: assert property (read_select_n == read_n)
		else $error("read select differs from read strobe");
	// upper byte enable loaded with the request
	a_ube_load: assert property (req_valid && req_ready |=> upper_byte_enable_n == !$past(req_be[1]))
		else $error("upper byte enable does not match request");
endmodule

// *** test/tb_ebc_bus_ctrl.sv ***
// self-checking bench for the bus sequencer
`timescale 1ns/100ps
module tb_ebc_bus_ctrl;
	import ebc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n, reg_wr, reg_rd, req_valid, req_write, rsp_valid, req_ready, read_n, wl_n, wh_n, ready_n;
	logic [3:0] reg_addr, rdy_dly;
	logic [15:0] reg_wdata, reg_rdata, req_wdata, rsp_rdata, ad_i, ad_o, q, l1, l2, l3;
	logic [23:0] req_addr, addr_out;
	logic [1:0] req_be, req_region;
	int miscompares = 0;
	int n_compared = 0;
	logic [15:0] cfg_tab [11] = '{16'h01F, 16'h03F, 16'h05F, 16'h07F, 16'h00F, 16'h01C, 16'h010, 16'h09F, 16'h19F,
		16'h11F, 16'h04F};
	logic [15:0] len_tab [11] = '{16'h4, 16'h6, 16'h6, 16'h8, 16'h6, 16'hA, 16'h22, 16'h4, 16'h4, 16'h4, 16'h8};

	ebc_bus_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_region(req_region),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_reference_clock_out(),
		.addr_out(addr_out), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(), .ale(), .read_n(read_n), .write_n(),
		.write_low_byte_n(wl_n), .write_high_byte_n(wh_n), .write_select_n(), .read_select_n(),
		.upper_byte_enable_n(), .ready_n(ready_n));
	ebc_mem_model u_mem (.ref_clk(ref_clk), .addr_out(addr_out), .ad_o(ad_o), .read_n(read_n),
		.write_low_byte_n(wl_n), .write_high_byte_n(wh_n), .ad_i(ad_i), .rdy_dly(rdy_dly), .ready_n(ready_n));

	// clock at 20 MHz
	always #25 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared=%0d miscompares=%0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic rwr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rrd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	// request held until taken, then wait for the end and for idle again
	task automatic xfer(input logic we, input logic [3:0] a, input logic [15:0] d, input logic [1:0] be,
		input logic [1:0] rg, output logic [15:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= we;
		req_addr <= {20'h00000, a};
		req_wdata <= d;
		req_be <= be;
		req_region <= rg;
		do begin
			@(posedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		r = rsp_rdata;
		check(16'(rsp_valid), 16'h0001);
		while (req_ready !== 1'b1 && n < 500) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	// watchdog: the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		close_out();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, req_valid, req_write} = 5'h00;
		{reg_addr, rdy_dly, reg_wdata, req_wdata, req_addr, req_be, req_region} = '0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rrd(i[3:0], q);
			check(q, 16'h001F);
		end
		rwr(4'h7, 16'hFFFF);
		rrd(4'h7, q);
		check(q, 16'h0000);
		rrd(4'h4, q);
		check(q, 16'h0010);
		// every latch mode and strobe placement, wait counts 0, 3 and 15, with write then read back
		for (int i = 0; i < 11; i++) begin
			rwr(i[3:0] % 4'h4, cfg_tab[i]);
			xfer(1'b1, i[3:0], 16'hA500 + 16'(i), 2'h3, i[1:0], q);
			xfer(1'b0, i[3:0], 16'h0000, 2'h3, i[1:0], q);
			check(q, 16'hA500 + 16'(i));
			rrd(4'h5, q);
			check(q, len_tab[i]);
		end
		// byte lane write keeps the other lane
		xfer(1'b1, 4'hF, 16'h1234, 2'h3, 2'h2, q);
		xfer(1'b1, 4'hF, 16'h5678, 2'h1, 2'h2, q);
		xfer(1'b0, 4'hF, 16'h0000, 2'h3, 2'h2, q);
		check(q, 16'h1278);
		// ready: fast, slow partner, then asynchronous mode
		rwr(4'h1, 16'h021F);
		xfer(1'b0, 4'h1, 16'h0000, 2'h3, 2'h1, q);
		rrd(4'h5, l1);
		rdy_dly <= 4'h6;
		xfer(1'b0, 4'h1, 16'h0000, 2'h3, 2'h1, q);
		rrd(4'h5, l2);
		check({15'h0000, l2 > l1}, 16'h0001);
		rdy_dly <= 4'h0;
		rwr(4'h1, 16'h061F);
		xfer(1'b0, 4'h1, 16'h0000, 2'h3, 2'h1, q);
		rrd(4'h5, l3);
		check({15'h0000, l3 >= l1 + 16'h2}, 16'h0001);
		check({15'h0000, l3 >= 16'h6}, 16'h0001);
		close_out();
	end
endmodule

bind ebc_bus_ctrl ebc_bus_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
	.req_ready(req_ready), .rsp_valid(rsp_valid), .bus_reference_clock_out(bus_reference_clock_out),
	.addr_out(addr_out), .ad_oe(ad_oe), .ale(ale), .read_n(read_n), .write_n(write_n),
	.write_low_byte_n(write_low_byte_n), .write_high_byte_n(write_high_byte_n),
	.write_select_n(write_select_n), .req_be(req_be), .read_select_n(read_select_n),
	.upper_byte_enable_n(upper_byte_enable_n));
